// ---- hw/adcss_map.svh ----
// Register offsets, field positions, reset values and layout masks of the scan/hit block
`ifndef ADCSS_MAP_SVH
`define ADCSS_MAP_SVH
`define ADCSS_OFF_SCAN_MASK 8'h00
`define ADCSS_OFF_HIT 8'h04
`define ADCSS_OFF_CTRL 8'h08
`define ADCSS_OFF_IRQ_STAT 8'h0C
`define ADCSS_OFF_IRQ_MASK 8'h10
`define ADCSS_RST_WORD 32'h0000_0000
`define ADCSS_IMPL_FULL 32'h7000_3FFF
`define ADCSS_IMPL_MID 32'h7000_0FFF
`define ADCSS_IMPL_SMALL 32'h7000_07FF
`define ADCSS_HIT_FIELD 32'h0000_3FFF
`define ADCSS_CTRL_MODE_LSB 0
`define ADCSS_CTRL_LEGACY_BIT 2
`define ADCSS_CTRL_AUTO_BIT 3
`define ADCSS_CTRL_SEL_LSB 8
`define ADCSS_CTRL_USED 32'h0000_1F0F
`define ADCSS_EV_HIT_BIT 0
`define ADCSS_EV_WRAP_BIT 1
`define ADCSS_EV_USED 32'h0000_0003
`define ADCSS_VARIANT_FULL 2'h0
`define ADCSS_VARIANT_MID 2'h1
`define ADCSS_VARIANT_SMALL 2'h2
`endif

// ---- hw/adcss_pkg.sv ----
// Types shared by the scan select and compare hit block
package adcss_pkg;
  typedef enum logic [1:0] {
    CMP_LESS = 2'h0,
    CMP_GREATER = 2'h1,
    CMP_INSIDE = 2'h2,
    CMP_OUTSIDE = 2'h3
  } adcss_cmp_mode_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h1,
    SEQ_SCAN = 2'h2
  } adcss_seq_state_t;

  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [15:0] data;
    logic [15:0] lo;
    logic [15:0] hi;
  } adcss_result_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } adcss_reg_req_t;
endpackage : adcss_pkg

// ---- hw/adcss_scan_hit.sv ----
// Scan input mask, compare hit flags and scan sequencer of the converter
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "adcss_map.svh"

module adcss_scan_hit
  import adcss_pkg::*;
#(
  parameter logic [1:0] VARIANT = `ADCSS_VARIANT_FULL
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire adcss_reg_req_t regReq,
  output logic [31:0] regRdData,
  input wire adcss_result_t result,
  input wire logic bufWrite,
  input wire logic [4:0] bufWriteChan,
  input wire logic convDone,
  output logic [4:0] convChan,
  output logic scanWrap,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Implemented bit layout
  localparam logic [31:0] IMPL_MASK = (VARIANT == `ADCSS_VARIANT_SMALL) ? `ADCSS_IMPL_SMALL :
                                      (VARIANT == `ADCSS_VARIANT_MID) ? `ADCSS_IMPL_MID :
                                      `ADCSS_IMPL_FULL;
  localparam logic [31:0] HIT_MASK = IMPL_MASK & `ADCSS_HIT_FIELD;

  logic [31:0] scanInputSelect;
  logic [31:0] compareHitFlag;
  logic [31:0] ctrl;
  logic [31:0] irqStat;
  logic [31:0] irqMask;
  adcss_seq_state_t seqState;
  logic [31:0] hitSet;
  logic [31:0] evSet;
  logic [31:0] next_hit;
  logic [31:0] next_stat;
  logic [4:0] nextSel;
  logic [4:0] firstSel;
  logic isMatch;
  logic scanOn;
  logic wrMask;
  logic wrHit;
  logic wrCtrl;
  logic wrStat;
  logic wrIrqMask;
  adcss_cmp_mode_t compareMode;

  assign compareMode = adcss_cmp_mode_t'(ctrl[`ADCSS_CTRL_MODE_LSB +: 2]);
  assign scanOn = ctrl[`ADCSS_CTRL_LEGACY_BIT] | ctrl[`ADCSS_CTRL_AUTO_BIT];

  assign wrMask = regReq.wr && (regReq.addr == `ADCSS_OFF_SCAN_MASK);
  assign wrHit = regReq.wr && (regReq.addr == `ADCSS_OFF_HIT);
  assign wrCtrl = regReq.wr && (regReq.addr == `ADCSS_OFF_CTRL);
  assign wrStat = regReq.wr && (regReq.addr == `ADCSS_OFF_IRQ_STAT);
  assign wrIrqMask = regReq.wr && (regReq.addr == `ADCSS_OFF_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////
  // Threshold compare
  always_comb begin
    case (compareMode)
      CMP_OUTSIDE: isMatch = (result.data < result.lo) || (result.data > result.hi);
      CMP_INSIDE: isMatch = (result.data >= result.lo) && (result.data <= result.hi);
      CMP_GREATER: isMatch = result.data > result.lo;
      CMP_LESS: isMatch = result.data < result.lo;
      default: isMatch = 1'b0;
    endcase
  end

  // Buffer writes only count in outside-window mode
  always_comb begin
    hitSet = 32'h0000_0000;
    if (result.valid && isMatch) begin
      hitSet[result.chan] = 1'b1;
    end
    if (bufWrite && compareMode == CMP_OUTSIDE) begin
      hitSet[bufWriteChan] = 1'b1;
    end
    hitSet = hitSet & HIT_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scanInputSelect <= `ADCSS_RST_WORD;
    end else if (wrMask) begin
      scanInputSelect <= regReq.wdata & IMPL_MASK;
    end
  end

  // Hardware set wins over a software write in the same cycle
  always_comb begin
    next_hit = wrHit ? (regReq.wdata & HIT_MASK) : compareHitFlag;
    next_hit = next_hit | hitSet;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      compareHitFlag <= `ADCSS_RST_WORD;
    end else begin
      compareHitFlag <= next_hit;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl <= `ADCSS_RST_WORD;
    end else if (wrCtrl) begin
      ctrl <= regReq.wdata & `ADCSS_CTRL_USED;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  always_comb begin
    evSet = 32'h0000_0000;
    evSet[`ADCSS_EV_HIT_BIT] = |hitSet;
    evSet[`ADCSS_EV_WRAP_BIT] = scanWrap;
    next_stat = irqStat;
    if (wrStat) begin
      next_stat = irqStat & ~regReq.wdata;
    end
    next_stat = next_stat | evSet;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqStat <= `ADCSS_RST_WORD;
    end else begin
      irqStat <= next_stat;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqMask <= `ADCSS_RST_WORD;
    end else if (wrIrqMask) begin
      irqMask <= regReq.wdata & `ADCSS_EV_USED;
    end
  end

  assign irq = |(irqStat & irqMask);

  ////////////////////////////////////////////////////////////////////////
  // Read port, data in the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData <= `ADCSS_RST_WORD;
    end else if (regReq.rd) begin
      case (regReq.addr)
        `ADCSS_OFF_SCAN_MASK: regRdData <= scanInputSelect;
        `ADCSS_OFF_HIT: regRdData <= compareHitFlag;
        `ADCSS_OFF_CTRL: regRdData <= ctrl;
        `ADCSS_OFF_IRQ_STAT: regRdData <= irqStat;
        `ADCSS_OFF_IRQ_MASK: regRdData <= irqMask;
        default: regRdData <= `ADCSS_RST_WORD;
      endcase
    end else begin
      regRdData <= `ADCSS_RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Scan sequencer
  function automatic logic [4:0] adcss_next_sel(input logic [31:0] m, input logic [4:0] cur);
    logic [4:0] idx;
    logic found;
    begin
      adcss_next_sel = cur;
      found = 1'b0;
      for (int i = 1; i <= 32; i++) begin
        idx = 5'(cur + 5'(i));
        if (!found && m[idx]) begin
          adcss_next_sel = idx;
          found = 1'b1;
        end
      end
    end
  endfunction : adcss_next_sel

  assign nextSel = adcss_next_sel(scanInputSelect, convChan);
  assign firstSel = adcss_next_sel(scanInputSelect, 5'h1F);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seqState <= SEQ_IDLE;
    end else begin
      case (seqState)
        SEQ_IDLE: if (scanOn && scanInputSelect != 32'h0000_0000) seqState <= SEQ_SCAN;
        SEQ_SCAN: if (!scanOn || scanInputSelect == 32'h0000_0000) seqState <= SEQ_IDLE;
        default: seqState <= SEQ_IDLE;
      endcase
    end
  end

  // A mask change mid-scan takes effect at the next advance
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      convChan <= 5'h00;
    end else if (!scanOn) begin
      convChan <= ctrl[`ADCSS_CTRL_SEL_LSB +: 5];
    end else if (seqState == SEQ_IDLE) begin
      convChan <= firstSel;
    end else if (convDone) begin
      convChan <= nextSel;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scanWrap <= 1'b0;
    end else begin
      scanWrap <= scanOn && seqState == SEQ_SCAN && convDone && scanInputSelect != 32'h0000_0000
                  && nextSel <= convChan;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_mask_sel;
    @(posedge sys_clk) disable iff (sys_rst)
    (seqState == SEQ_SCAN && scanOn && convDone && !wrMask && !wrCtrl && scanInputSelect != 32'h0000_0000)
      |=> scanInputSelect[convChan];
  endproperty
  a_mask_sel: assert property (p_mask_sel) else $error("scan visited unselected input");

  property p_mask_rsvd;
    @(posedge sys_clk) disable iff (sys_rst)
    regReq.rd && regReq.addr == `ADCSS_OFF_SCAN_MASK |=> (regRdData & ~IMPL_MASK) == 32'h0;
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd) else $error("reserved mask bits read nonzero");

  property p_outside_buf;
    @(posedge sys_clk) disable iff (sys_rst)
    bufWrite && compareMode == CMP_OUTSIDE && HIT_MASK[bufWriteChan]
      |=> compareHitFlag[$past(bufWriteChan)];
  endproperty
  a_outside_buf: assert property (p_outside_buf) else $error("buffer write did not set hit");

  property p_no_false_hit;
    @(posedge sys_clk) disable iff (sys_rst)
    compareMode != CMP_OUTSIDE && !(result.valid && isMatch) && !wrHit
      |=> compareHitFlag == $past(compareHitFlag);
  endproperty
  a_no_false_hit: assert property (p_no_false_hit) else $error("hit set without match");

  property p_hit_upper;
    @(posedge sys_clk) disable iff (sys_rst)
    (compareHitFlag & ~HIT_MASK) == 32'h0;
  endproperty
  a_hit_upper: assert property (p_hit_upper) else $error("hit flag outside field");

  property p_greater;
    @(posedge sys_clk) disable iff (sys_rst)
    result.valid && compareMode == CMP_GREATER && result.data > result.lo && HIT_MASK[result.chan]
      |=> compareHitFlag[$past(result.chan)] && irqStat[`ADCSS_EV_HIT_BIT];
  endproperty
  a_greater: assert property (p_greater) else $error("greater match missed");

  property p_single_sel;
    @(posedge sys_clk) disable iff (sys_rst)
    !scanOn && !wrCtrl ##1 !scanOn |-> convChan == ctrl[`ADCSS_CTRL_SEL_LSB +: 5];
  endproperty
  a_single_sel: assert property (p_single_sel) else $error("single select not applied");

  property p_ascend;
    @(posedge sys_clk) disable iff (sys_rst)
    seqState == SEQ_SCAN && scanOn && convDone && !wrCtrl && nextSel > convChan
      |=> convChan > $past(convChan) && !scanWrap;
  endproperty
  a_ascend: assert property (p_ascend) else $error("scan order not ascending");

  property p_less;
    @(posedge sys_clk) disable iff (sys_rst)
    result.valid && compareMode == CMP_LESS && result.data < result.lo && HIT_MASK[result.chan]
      |=> compareHitFlag[$past(result.chan)];
  endproperty
  a_less: assert property (p_less) else $error("less match missed");

  property p_inside;
    @(posedge sys_clk) disable iff (sys_rst)
    result.valid && compareMode == CMP_INSIDE && result.data >= result.lo && result.data <= result.hi
      && HIT_MASK[result.chan] |=> compareHitFlag[$past(result.chan)];
  endproperty
  a_inside: assert property (p_inside) else $error("inside match missed");

  property p_outside_res;
    @(posedge sys_clk) disable iff (sys_rst)
    result.valid && compareMode == CMP_OUTSIDE && (result.data < result.lo || result.data > result.hi)
      && HIT_MASK[result.chan] |=> compareHitFlag[$past(result.chan)];
  endproperty
  a_outside_res: assert property (p_outside_res) else $error("outside match missed");

  property p_hit_sticky;
    @(posedge sys_clk) disable iff (sys_rst)
    !wrHit |=> (compareHitFlag & $past(compareHitFlag)) == $past(compareHitFlag);
  endproperty
  a_hit_sticky: assert property (p_hit_sticky) else $error("hit flag lost without write");

  property p_miss_keep;
    @(posedge sys_clk) disable iff (sys_rst)
    result.valid && compareMode == CMP_GREATER && result.data <= result.lo && !wrHit
      |=> compareHitFlag == $past(compareHitFlag);
  endproperty
  a_miss_keep: assert property (p_miss_keep) else $error("hit set on a miss");

  property p_mask_write;
    @(posedge sys_clk) disable iff (sys_rst)
    wrMask |=> scanInputSelect == ($past(regReq.wdata) & IMPL_MASK);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not taken");

  property p_hit_write;
    @(posedge sys_clk) disable iff (sys_rst)
    wrHit && hitSet == 32'h0000_0000 |=> compareHitFlag == ($past(regReq.wdata) & HIT_MASK);
  endproperty
  a_hit_write: assert property (p_hit_write) else $error("hit write not taken");

  // Lowest selected input first, so a scan never skips the bottom of the mask
  property p_first_sel;
    @(posedge sys_clk) disable iff (sys_rst)
    seqState == SEQ_IDLE && scanOn && scanInputSelect != 32'h0000_0000 && !wrMask && !wrCtrl
      |=> scanInputSelect[convChan] && (scanInputSelect & ((32'h1 << convChan) - 32'h1)) == 32'h0;
  endproperty
  a_first_sel: assert property (p_first_sel) else $error("scan did not start at lowest input");
  property p_wrap_low;
    @(posedge sys_clk) disable iff (sys_rst)
    scanWrap && !$past(wrMask)
      |-> scanInputSelect[convChan] && (scanInputSelect & ((32'h1 << convChan) - 32'h1)) == 32'h0;
  endproperty
  a_wrap_low: assert property (p_wrap_low) else $error("wrap did not return to lowest input");

  property p_wrap_irq;
    @(posedge sys_clk) disable iff (sys_rst)
    scanWrap |=> irqStat[`ADCSS_EV_WRAP_BIT];
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap event not recorded");

  property p_hit_rd;
    @(posedge sys_clk) disable iff (sys_rst)
    regReq.rd && regReq.addr == `ADCSS_OFF_HIT |=> (regRdData & ~HIT_MASK) == 32'h0;
  endproperty
  a_hit_rd: assert property (p_hit_rd) else $error("hit read outside field");

endmodule : adcss_scan_hit

// ---- sim/tb_adcss_scan_hit.sv ----
// Self-checking bench for the scan select and compare hit block
`timescale 1ns/10ps
`include "adcss_map.svh"

module tb_adcss_scan_hit
  import adcss_pkg::*;
;
  logic sysClk = 1'b0;
  logic sysRst = 1'b1;
  adcss_reg_req_t regReq = '0;
  logic [31:0] regRdData;
  logic [31:0] regRdDataMid;
  logic [31:0] regRdDataSmall;
  adcss_result_t result = '0;
  logic bufWrite = 1'b0;
  logic [4:0] bufWriteChan = 5'h00;
  logic convDone = 1'b0;
  logic [4:0] convChan;
  logic scanWrap;
  logic irq;
  int errCount = 0;
  int nTests = 0;
  // Boundary data per compare mode, lo 0x64 and hi 0xC8
  logic [15:0] matchData [4] = '{16'h0032, 16'h0096, 16'h00C8, 16'h0063};
  logic [15:0] missData [4] = '{16'h0064, 16'h0064, 16'h00C9, 16'h00C8};

  always #5 sysClk = ~sysClk;

  adcss_scan_hit #(.VARIANT(`ADCSS_VARIANT_FULL)) adcss_scan_hit_i (
    .sys_clk(sysClk),
    .sys_rst(sysRst),
    .regReq(regReq),
    .regRdData(regRdData),
    .result(result),
    .bufWrite(bufWrite),
    .bufWriteChan(bufWriteChan),
    .convDone(convDone),
    .convChan(convChan),
    .scanWrap(scanWrap),
    .irq(irq)
  );

  // Reduced variants run on the same stimulus; only their read data are compared
  if (1'b1) begin : gMid
    adcss_scan_hit #(.VARIANT(`ADCSS_VARIANT_MID)) adcss_scan_hit_i (
      .sys_clk(sysClk),
      .sys_rst(sysRst),
      .regReq(regReq),
      .regRdData(regRdDataMid),
      .result(result),
      .bufWrite(bufWrite),
      .bufWriteChan(bufWriteChan),
      .convDone(convDone),
      .convChan(),
      .scanWrap(),
      .irq()
    );
  end

  if (1'b1) begin : gSmall
    adcss_scan_hit #(.VARIANT(`ADCSS_VARIANT_SMALL)) adcss_scan_hit_i (
      .sys_clk(sysClk),
      .sys_rst(sysRst),
      .regReq(regReq),
      .regRdData(regRdDataSmall),
      .result(result),
      .bufWrite(bufWrite),
      .bufWriteChan(bufWriteChan),
      .convDone(convDone),
      .convChan(),
      .scanWrap(),
      .irq()
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("Counts: %0d compares, %0d mismatches", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task regWrite(input logic [7:0] addr, input logic [31:0] data);
    @(posedge sysClk);
    regReq.wr <= 1'b1;
    regReq.addr <= addr;
    regReq.wdata <= data;
    @(posedge sysClk);
    regReq.wr <= 1'b0;
    #1;
  endtask : regWrite

  // Read data stand only in the cycle after the strobe
  task readExpect(input logic [7:0] addr, input logic [31:0] exp);
    @(posedge sysClk);
    regReq.rd <= 1'b1;
    regReq.addr <= addr;
    @(posedge sysClk);
    regReq.rd <= 1'b0;
    #1;
    check(regRdData, exp);
  endtask : readExpect

  task sendRes(input logic [4:0] chan, input logic [15:0] data);
    @(posedge sysClk);
    result <= '{valid: 1'b1, chan: chan, data: data, lo: 16'h0064, hi: 16'h00C8};
    @(posedge sysClk);
    result.valid <= 1'b0;
  endtask : sendRes

  task pulseBuf(input logic [4:0] chan);
    @(posedge sysClk);
    bufWrite <= 1'b1;
    bufWriteChan <= chan;
    @(posedge sysClk);
    bufWrite <= 1'b0;
  endtask : pulseBuf

  // Wrap is a one-cycle pulse, so it is looked at right after the taking edge
  task step(input logic [4:0] expChan, input logic expWrap);
    @(posedge sysClk);
    convDone <= 1'b1;
    @(posedge sysClk);
    convDone <= 1'b0;
    #1;
    check({27'h0, convChan}, {27'h0, expChan});
    check({31'h0, scanWrap}, {31'h0, expWrap});
  endtask : step

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sysClk);
    sysRst <= 1'b0;
    readExpect(`ADCSS_OFF_SCAN_MASK, 32'h0000_0000);
    readExpect(`ADCSS_OFF_HIT, 32'h0000_0000);
    regWrite(`ADCSS_OFF_SCAN_MASK, 32'hFFFF_FFFF);
    readExpect(`ADCSS_OFF_SCAN_MASK, 32'h7000_3FFF);
    check(regRdDataMid, 32'h7000_0FFF);
    check(regRdDataSmall, 32'h7000_07FF);
    regWrite(`ADCSS_OFF_SCAN_MASK, 32'h0000_0000);
    readExpect(`ADCSS_OFF_SCAN_MASK, 32'h0000_0000);
    regWrite(`ADCSS_OFF_HIT, 32'hFFFF_FFFF);
    readExpect(`ADCSS_OFF_HIT, 32'h0000_3FFF);
    check(regRdDataMid, 32'h0000_0FFF);
    check(regRdDataSmall, 32'h0000_07FF);
    readExpect(8'h40, 32'h0000_0000);
    $display("Test registers done");
    for (int m = 0; m < 4; m++) begin
      regWrite(`ADCSS_OFF_CTRL, 32'(m));
      regWrite(`ADCSS_OFF_HIT, 32'h0000_0000);
      sendRes(5'(m + 2), missData[m]);
      readExpect(`ADCSS_OFF_HIT, 32'h0000_0000);
      sendRes(5'(m + 2), matchData[m]);
      readExpect(`ADCSS_OFF_HIT, 32'h1 << (m + 2));
    end
    $display("Test compare modes done");
    // Buffer writes only count in outside-window mode
    regWrite(`ADCSS_OFF_CTRL, 32'h0000_0000);
    regWrite(`ADCSS_OFF_HIT, 32'h0000_0000);
    pulseBuf(5'h06);
    readExpect(`ADCSS_OFF_HIT, 32'h0000_0000);
    regWrite(`ADCSS_OFF_CTRL, 32'h0000_0003);
    pulseBuf(5'h05);
    readExpect(`ADCSS_OFF_HIT, 32'h0000_0020);
    pulseBuf(5'h14);
    readExpect(`ADCSS_OFF_HIT, 32'h0000_0020);
    $display("Test buffer writes done");
    readExpect(`ADCSS_OFF_IRQ_STAT, 32'h0000_0001);
    check({31'h0, irq}, 32'h0);
    regWrite(`ADCSS_OFF_IRQ_MASK, 32'h0000_0001);
    check({31'h0, irq}, 32'h1);
    regWrite(`ADCSS_OFF_IRQ_STAT, 32'h0000_0001);
    check({31'h0, irq}, 32'h0);
    readExpect(`ADCSS_OFF_IRQ_STAT, 32'h0000_0000);
    $display("Test interrupt done");
    // Inputs 0, 2 and 30 cover both implemented fields of the mask
    regWrite(`ADCSS_OFF_SCAN_MASK, 32'h4000_0005);
    regWrite(`ADCSS_OFF_CTRL, 32'h0000_0004);
    repeat (3) @(posedge sysClk);
    #1;
    check({27'h0, convChan}, 32'h0);
    step(5'h02, 1'b0);
    step(5'h1E, 1'b0);
    step(5'h00, 1'b1);
    readExpect(`ADCSS_OFF_IRQ_STAT, 32'h0000_0002);
    regWrite(`ADCSS_OFF_CTRL, 32'h0000_0008);
    step(5'h02, 1'b0);
    $display("Test scan sequence done");
    // Scan off: the single select field takes over one edge after the write
    regWrite(`ADCSS_OFF_CTRL, 32'h0000_0700);
    @(posedge sysClk);
    #1;
    check({27'h0, convChan}, 32'h0000_0007);
    $display("Test single select done");
    // Reset with the scan off at single select 7 and a wrap event pending and enabled
    regWrite(`ADCSS_OFF_IRQ_MASK, 32'h0000_0003);
    check({31'h0, irq}, 32'h1);
    @(posedge sysClk);
    sysRst <= 1'b1;
    repeat (2) @(posedge sysClk);
    sysRst <= 1'b0;
    #1;
    check({27'h0, convChan}, 32'h0);
    check({31'h0, irq}, 32'h0);
    readExpect(`ADCSS_OFF_SCAN_MASK, 32'h0000_0000);
    readExpect(`ADCSS_OFF_HIT, 32'h0000_0000);
    readExpect(`ADCSS_OFF_IRQ_STAT, 32'h0000_0000);
    $display("Test reset done");
    summarize;
  end

  // Tests take well under a thousand cycles
  initial begin
    #100000;
    errCount++;
    summarize;
  end
endmodule : tb_adcss_scan_hit
